/* rtl/interval_prescaler.sv */
`timescale 1ns/1ps
`include "interval_timer_cfg.svh"

// divides pclk by sixteen into a one-cycle enable
module interval_prescaler (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic run,
    output logic      tick
);

    logic [`PRESCALE_WIDTH-1:0] div_reg;
    logic [`PRESCALE_WIDTH-1:0] div_next;
    logic                       tick_next;

    // frozen while halted, so no pending edge is lost
    assign div_next  = run ? div_reg + `PRESCALE_WIDTH'(1) : div_reg;
    assign tick_next = run ? (div_reg == `PRESCALE_LAST) : tick;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= '0;
            tick    <= 1'b0;
        end else begin
            div_reg <= div_next;
            tick    <= tick_next;
        end
    end

endmodule

/* rtl/interval_timer_cfg.svh */
`ifndef INTERVAL_TIMER_CFG_SVH
`define INTERVAL_TIMER_CFG_SVH

// register byte offsets
`define OFF_MODE        8'h00
`define OFF_STATUS      8'h04
`define OFF_VALUE_ACK   8'h08
`define OFF_VALUE_PEEK  8'h0C
`define OFF_EVENT       8'h10
`define OFF_EVENT_MASK  8'h14

// mode register layout and reset value
`define MODE_RESET         32'h000F_FFFF
`define MODE_IRQ_EN_BIT    25
`define MODE_TIMER_EN_BIT  24
`define LIMIT_MSB          19
`define LIMIT_RESET        20'hF_FFFF

// value register layout
`define COUNT_MSB          19
`define ELAPSED_LSB        20
`define ELAPSED_MSB        31
`define ELAPSED_FULL       12'hFFF

// status register layout
`define STATUS_FLAG_BIT    0

// extra event register layout
`define EVT_WIDTH          2
`define EVT_LOST_BIT       0
`define EVT_STOP_BIT       1

// prescaler: master clock divided by sixteen
`define PRESCALE_WIDTH     4
`define PRESCALE_LAST      4'hF

`endif

/* rtl/interval_timer_pkg.sv */
package interval_timer_pkg;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b01,
        ST_ANSWER = 2'b10
    } apb_state_t;

    typedef logic [19:0] interval_count_t;
    typedef logic [11:0] elapsed_count_t;

endpackage

/* rtl/periodic_interval_timer.sv */
// Contract
// - a 20-bit interval counter and a 12-bit elapsed interval counter
// - the interval counter advances on pclk divided by sixteen, the elapsed counter once per wrap
// - interval count rises from zero, wraps at limit, elapsed count increments
// - each interval lasts limit plus one divided ticks; limit is 20 bits
// - wrap sets the flag; irq while flag and irq enable both set
// - writing a new limit never resets or restarts the counters
// - ack read returns both counts, clears elapsed count and flag
// - peek read returns both counts with no side effect
// - timer enable resets off and takes effect only at count zero
// - after disable, counting finishes the interval then stops at zero
// - all counting halts while the core is in debug state
// - mode: irq enable bit 25, timer enable bit 24, limit low bits
// - value words: elapsed count bits 31:20, interval count bits 19:0
// - status bit zero shows limit reached since the last ack read
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`include "interval_timer_cfg.svh"

module periodic_interval_timer
    import interval_timer_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic        debug_halt,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             interval_irq
);

    // packs the two counters into one read word
    function automatic logic [31:0] value_word(
        input elapsed_count_t  elapsed,
        input interval_count_t current
    );
        logic [31:0] word;
        word = '0;
        word[`ELAPSED_MSB:`ELAPSED_LSB] = elapsed;
        word[`COUNT_MSB:0]              = current;
        return word;
    endfunction

    // packs the mode fields into one read word
    function automatic logic [31:0] mode_word_of(
        input interval_count_t limit,
        input logic            timer_en,
        input logic            irq_en
    );
        logic [31:0] word;
        word = '0;
        word[`MODE_IRQ_EN_BIT]   = irq_en;
        word[`MODE_TIMER_EN_BIT] = timer_en;
        word[`LIMIT_MSB:0]       = limit;
        return word;
    endfunction

    // sticky bit update, a set in the same cycle beats the clear
    function automatic logic [`EVT_WIDTH-1:0] sticky(
        input logic [`EVT_WIDTH-1:0] held,
        input logic [`EVT_WIDTH-1:0] set,
        input logic                  clear
    );
        return set | (held & ~{`EVT_WIDTH{clear}});
    endfunction

    // mode register fields
    interval_count_t         interval_limit_reg;
    logic                    interval_timer_enable_reg;
    logic                    interval_irq_enable_reg;

    // counters and flags
    interval_count_t         current_interval_count_reg;
    interval_count_t         current_interval_count_next;
    elapsed_count_t          elapsed_interval_count_reg;
    elapsed_count_t          elapsed_interval_count_next;
    logic                    interval_reached_flag_reg;
    logic                    interval_reached_flag_next;
    logic [`EVT_WIDTH-1:0]   event_reg;
    logic [`EVT_WIDTH-1:0]   event_next;
    logic [`EVT_WIDTH-1:0]   event_mask_reg;

    // bus side
    apb_state_t              state_reg;
    apb_state_t              state_next;
    logic [31:0]             rdata_reg;
    logic [31:0]             rdata_next;
    logic                    ready_reg;
    logic                    err_reg;
    logic                    err_next;
    logic                    irq_reg;
    logic                    irq_next;

    // prescaler
    logic                    tick;

    interval_prescaler u_prescaler (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (~debug_halt),
        .tick    (tick)
    );

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire sel_mode    = (paddr == `OFF_MODE);
    wire sel_status  = (paddr == `OFF_STATUS);
    wire sel_ack     = (paddr == `OFF_VALUE_ACK);
    wire sel_peek    = (paddr == `OFF_VALUE_PEEK);
    wire sel_event   = (paddr == `OFF_EVENT);
    wire sel_mask    = (paddr == `OFF_EVENT_MASK);
    wire mapped      = sel_mode | sel_status | sel_ack | sel_peek | sel_event | sel_mask;

    wire setup       = psel & ~penable & (state_reg == ST_IDLE);
    wire done        = psel & penable & ready_reg;
    wire rd_setup    = setup & ~pwrite;
    wire wr_done     = done & pwrite & mapped;

    wire ack_read    = rd_setup & sel_ack;
    wire event_read  = rd_setup & sel_event;
    wire mode_write  = wr_done & sel_mode;
    wire mask_write  = wr_done & sel_mask;

    // mode fields as written
    wire interval_count_t wr_limit    = pwdata[`LIMIT_MSB:0];
    wire                  wr_timer_en = pwdata[`MODE_TIMER_EN_BIT];
    wire                  wr_irq_en   = pwdata[`MODE_IRQ_EN_BIT];

    // ------------------------------------------------------------
    // counting
    // ------------------------------------------------------------
    wire at_zero     = (current_interval_count_reg == '0);
    wire at_limit    = (current_interval_count_reg == interval_limit_reg);
    // enable is only looked at while the count rests at zero
    wire running     = interval_timer_enable_reg | ~at_zero;
    wire step        = tick & running & ~debug_halt;
    wire wrap        = step & at_limit;
    wire stop_event  = wrap & ~interval_timer_enable_reg;
    wire lost_event  = wrap & ~ack_read & (elapsed_interval_count_reg == `ELAPSED_FULL);

    assign current_interval_count_next =
        wrap ? '0 :
        step ? current_interval_count_reg + 20'h0_0001 :
               current_interval_count_reg;

    // ack clear and a wrap in one cycle leave a count of one
    wire elapsed_count_t elapsed_base = ack_read ? '0 : elapsed_interval_count_reg;
    assign elapsed_interval_count_next =
        wrap ? elapsed_base + 12'h001 : elapsed_base;

    assign interval_reached_flag_next =
        wrap | (interval_reached_flag_reg & ~ack_read);

    wire [`EVT_WIDTH-1:0] event_set = {stop_event, lost_event};
    assign event_next = sticky(event_reg, event_set, event_read);

    // flag reaches the pin only through its enable
    wire flag_irq    = interval_reached_flag_reg & interval_irq_enable_reg;
    wire event_irq   = |(event_reg & event_mask_reg);
    assign irq_next  = flag_irq | event_irq;

    // ------------------------------------------------------------
    // read data and answer
    // ------------------------------------------------------------
    wire [31:0] mode_word = mode_word_of(interval_limit_reg, interval_timer_enable_reg,
                                         interval_irq_enable_reg);

    wire [31:0] status_word = {31'h0000_0000, interval_reached_flag_reg};
    wire [31:0] count_word  = value_word(elapsed_interval_count_reg,
                                         current_interval_count_reg);
    wire [31:0] event_word  = {30'h0000_0000, event_reg};
    wire [31:0] mask_word   = {30'h0000_0000, event_mask_reg};

    assign rdata_next =
        ~rd_setup  ? rdata_reg   :
        sel_mode   ? mode_word   :
        sel_status ? status_word :
        sel_ack    ? count_word  :
        sel_peek   ? count_word  :
        sel_event  ? event_word  :
        sel_mask   ? mask_word   :
                     32'h0000_0000;

    assign err_next =
        setup ? ~mapped :
        done  ? 1'b0    :
                err_reg;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (setup) begin
                    state_next = ST_ANSWER;
                end
            end
            ST_ANSWER: begin
                if (done) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_reg <= 1'b0;
        end else begin
            ready_reg <= (state_next == ST_ANSWER);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_reg <= 1'b0;
        end else begin
            err_reg <= err_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // mode register; the counters are not touched by a write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interval_limit_reg        <= `LIMIT_RESET;
            interval_timer_enable_reg <= 1'b0;
            interval_irq_enable_reg   <= 1'b0;
        end else if (mode_write) begin
            interval_limit_reg        <= wr_limit;
            interval_timer_enable_reg <= wr_timer_en;
            interval_irq_enable_reg   <= wr_irq_en;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_mask_reg <= '0;
        end else if (mask_write) begin
            event_mask_reg <= pwdata[`EVT_WIDTH-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            current_interval_count_reg <= '0;
        end else begin
            current_interval_count_reg <= current_interval_count_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            elapsed_interval_count_reg <= '0;
        end else begin
            elapsed_interval_count_reg <= elapsed_interval_count_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interval_reached_flag_reg <= 1'b0;
        end else begin
            interval_reached_flag_reg <= interval_reached_flag_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_reg <= '0;
        end else begin
            event_reg <= event_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    assign prdata       = rdata_reg;
    assign pready       = ready_reg;
    assign pslverr      = err_reg;
    assign interval_irq = irq_reg;

endmodule

/* testbench/interval_timer_properties.sv */
`timescale 1ns/1ps
module interval_timer_properties (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        debug_halt,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        interval_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup; psel && !penable; endsequence
    sequence s_mode_wr; psel && penable && pready && pwrite && paddr == 8'h00; endsequence
    sequence s_mode_rd; s_setup ##0 (!pwrite && paddr == 8'h00); endsequence
    property p_ready; s_setup |=> pready; endproperty
    property p_one; pready |=> !pready; endproperty
    property p_err; s_setup ##0 (paddr > 8'h14) |=> pready && pslverr; endproperty
    property p_ok; s_setup ##0 (paddr <= 8'h14 && paddr[1:0] == 2'b00) |=> !pslverr; endproperty
    property p_stat; s_setup ##0 (!pwrite && paddr == 8'h04) |=> prdata[31:1] == 31'h0;
    endproperty
    property p_mode; s_mode_wr ##2 s_mode_rd |=> prdata == ($past(pwdata, 3) & 32'h030F_FFFF);
    endproperty
    property p_irq_rst; $rose(presetn) |-> !interval_irq; endproperty
    property p_hold; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
    property p_halt; $past(debug_halt, 2) && !$past(psel, 2) |-> !$rose(interval_irq);
    endproperty
    a_ready: assert property (p_ready) else $error("no answer after setup");
    a_one: assert property (p_one) else $error("answer longer than one cycle");
    a_err: assert property (p_err) else $error("unmapped access not refused");
    a_ok: assert property (p_ok) else $error("mapped access refused");
    a_stat: assert property (p_stat) else $error("status reserved bits set");
    a_mode: assert property (p_mode) else $error("mode readback wrong");
    a_irq_rst: assert property (p_irq_rst) else $error("irq after reset");
    a_hold: assert property (p_hold) else $error("read data moved");
    a_halt: assert property (p_halt) else $error("irq rose while halted");
endmodule
bind periodic_interval_timer interval_timer_properties u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .debug_halt(debug_halt), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .interval_irq(interval_irq));

/* testbench/periodic_interval_timer_tb.sv */
`timescale 1ns/1ps
module periodic_interval_timer_tb;
    logic        pclk, presetn, psel, penable, pwrite, debug_halt;
    logic        pready, pslverr, interval_irq, rerr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat, p1;
    int          failures, total_checks, cyc, lim, i;
    int          seed = 48;

    periodic_interval_timer dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .debug_halt(debug_halt),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .interval_irq(interval_irq));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // cycle count and hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc > 20000) begin
            failures++;
            close_out();
        end
    end

    task close_out;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd(input logic [7:0] a); xfer(1'b0, a, 32'h0); endtask
    task wr(input logic [7:0] a, input logic [31:0] d); xfer(1'b1, a, d); endtask

    // waits until the interval count rests at one or below, safe for any new limit of two or more
    task sync;
        do begin
            rd(8'h0C);
        end while (rdat[19:0] > 20'h1);
    endtask

    task measure(input int l);
        int          t0, per;
        logic [31:0] a0;
        per = 16 * (l + 1);
        sync();
        p1 = rdat;
        wr(8'h00, 32'h0300_0000 | l);
        rd(8'h00);
        chk(rdat, 32'h0300_0000 | l);
        rd(8'h0C);
        chk(rdat[31:20], p1[31:20]);
        t0 = cyc;
        rd(8'h08);
        a0 = rdat;
        while (cyc < t0 + 3 * per) @(posedge pclk);
        rd(8'h0C);
        chk(rdat, {12'h003, a0[19:0]});
        rd(8'h04);
        chk(rdat, 32'h1);
        chk(interval_irq, 1'b1);
        while (cyc < t0 + 4 * per) @(posedge pclk);
        rd(8'h0C);
        chk(rdat, {12'h004, a0[19:0]});
    endtask

    initial begin
        {psel, penable, pwrite, debug_halt} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        presetn = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 6; i++) begin
            rd(8'(4 * i));
            chk(rdat, i == 0 ? 32'h000F_FFFF : 32'h0);
        end
        rd(8'h18);
        chk(rerr, 1'b1);
        chk(rdat, 32'h0);
        for (i = 0; i < 3; i++) begin
            lim = (i == 0) ? 3 : 3 + ($random(seed) & 7);
            measure(lim);
        end
        // freeze in debug state
        debug_halt <= 1'b1;
        rd(8'h0C);
        p1 = rdat;
        repeat (40) @(posedge pclk);
        rd(8'h0C);
        chk(rdat, p1);
        debug_halt <= 1'b0;
        wr(8'h00, 32'h0100_0000 | lim);
        repeat (2) @(posedge pclk);
        chk(interval_irq, 1'b0);
        wr(8'h14, 32'h2);
        wr(8'h00, lim);
        repeat (40 * (lim + 1)) @(posedge pclk);
        rd(8'h0C);
        p1 = rdat;
        repeat (40) @(posedge pclk);
        rd(8'h0C);
        chk(p1[19:0], 20'h0);
        chk(rdat[19:0], 20'h0);
        chk(interval_irq, 1'b1);
        rd(8'h10);
        chk(rdat, 32'h2);
        repeat (2) @(posedge pclk);
        chk(interval_irq, 1'b0);
        rd(8'h08);
        rd(8'h04);
        chk(rdat, 32'h0);
        close_out();
    end
endmodule
